// ===== rtl/nvm_cfg.svh
`ifndef NVM_CFG_SVH
`define NVM_CFG_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL        12'hfe0
`define IDX_STATUS      12'hfe1
`define IDX_WTIME       12'hfe2
`define ADDR_W          14

// Control register fields
`define KEY_HI          7
`define KEY_LO          4
`define STOP_BIT        2
`define KEY_ENABLE      4'h3
`define KEY_LOCK        4'hc

// Status register fields
`define ST_BUSY_BIT     0
`define ST_READY_BIT    1

// Write-time select field
`define WT_HI           2
`define WT_CODE_MAX     3'h4
`define WT_RESET        3'h0
`define WT_FAST_EXP     5'h10
`define WT_SLOW_EXP     5'h07

// Temporary buffer
`define BUF_BYTES       7'h40

// Warm-up lengths, in fast cycles and in slow ticks
`define WARM_FAST       11'h400
`define WARM_SLOW       11'h008

// Production write time
`define WRITE_TIME_NS   4000000
`define CLK_PERIOD_NS   50
`define WRITE_CYCLES    (`WRITE_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== rtl/nvm_pkg.sv
package nvm_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_PROG = 2'b10,
        ST_WARM = 2'b11
    } seq_state_t;

endpackage : nvm_pkg

// ===== rtl/flash_write_protect_abort_warmup.sv
// Function
// - Emulation: write-time code 000..100 selects 2^16..2^12 fast or 2^7..2^3 slow cycles per clock select; 101..111 reserved.
// - Production: code is stored and read back only; write lasts about 4 ms.
// - Write-time register returns only its low three bits as stored.
// - Flash programming allowed only while key holds 0011; 1100 locks it.
// - Reset loads the key with 1100.
// - Key writes take effect only when fetching from RAM.
// - Forced stop clears byte counter, aborts write, starts warm-up holding the CPU.
// - Busy flag clears when the forced-stop warm-up ends.
// - Forced-stop warm-up lasts 2^10 fast cycles or 2^3 slow cycles per clock select.
// - After stop, next write is byte one and sets busy; 64 bytes then needed.
// - Stop with 1 to 63 bytes loaded leaves the page unprogrammed.
// - Stop after 64 bytes leaves the page contents undefined.
// - Forced-stop writes take effect only when fetching from RAM.
// - During warm-up the CPU is held; interrupts wait until it ends.
// - Forced stop while not busy causes no warm-up or wait.
// - Flash circuit power restored after shutdown gets a warm-up when idle or loading bytes.
// - Power-up wait is 2^10 fast or 2^3 slow cycles; stop exit adds it.
// - Emulation keeps the same register and wait behaviour as production.
// - Forced-stop bit clears itself after a one is written.
`timescale 1ns/100ps
`include "nvm_cfg.svh"

module flash_write_protect_abort_warmup
    import nvm_pkg::*;
#(
    parameter bit          EMULATION    = 1'b1,
    parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // CPU context
    input  wire logic        fetch_from_ram,
    input  wire logic        clock_source_select,
    input  wire logic        slow_tick,
    input  wire logic        power_restore,
    // Flash write port from the CPU
    input  wire logic        flash_wr_strobe,
    input  wire logic [7:0]  flash_wr_data,
    // Temporary buffer and array
    output logic             buf_we,
    output logic [5:0]       buf_index,
    output logic [7:0]       buf_data,
    output logic             prog_start,
    output logic             prog_done,
    output logic             prog_abort,
    // Status
    output logic             write_busy_flag,
    output logic             cpu_wait
);

    localparam logic [16:0] WRITE_LEN = WRITE_CYCLES[16:0];

    seq_state_t  state;
    seq_state_t  next_state;
    seq_state_t  ret_state;
    logic [3:0]  write_protect_key;
    logic [2:0]  write_duration_code;
    logic        forced_stop_bit;
    logic [6:0]  byte_count;
    logic [16:0] tcount;
    logic [16:0] prog_len;
    logic        prog_slow;
    logic        warm_slow;
    logic        warm_from_stop;
    logic        warm_done;
    logic        prog_end;
    logic        wr_accept;
    logic        stop_req;
    logic        bus_wr;
    logic        bus_rd;
    logic [11:0] reg_idx;
    logic        mapped;
    logic [31:0] next_rdata;
    logic [2:0]  eff_code;

    assign reg_idx = paddr[`ADDR_W-1:2];
    assign mapped  = (paddr[1:0] == 2'h0) && (paddr[15:`ADDR_W] == 2'h0) &&
                     (reg_idx == `IDX_CTRL || reg_idx == `IDX_STATUS || reg_idx == `IDX_WTIME);
    assign bus_wr  = psel && penable && pready && pwrite && mapped;
    assign bus_rd  = psel && !penable && !pwrite;

    // APB: one wait-free access cycle, answer registered at its start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped;
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        if (reg_idx == `IDX_CTRL) begin
            next_rdata[`KEY_HI:`KEY_LO] = write_protect_key;
        end else if (reg_idx == `IDX_STATUS) begin
            next_rdata[`ST_BUSY_BIT]  = write_busy_flag;
            next_rdata[`ST_READY_BIT] = !cpu_wait;
        end else if (reg_idx == `IDX_WTIME) begin
            next_rdata[`WT_HI:0] = write_duration_code;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (bus_rd) begin
            prdata <= mapped ? next_rdata : 32'h0;
        end
    end

    // Key: locked from reset, only RAM-fetched writes change it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_protect_key <= `KEY_LOCK;
        end else if (bus_wr && reg_idx == `IDX_CTRL && fetch_from_ram) begin
            write_protect_key <= pwdata[`KEY_HI:`KEY_LO];
        end
    end

    // Stop bit lives one cycle and then clears itself
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            forced_stop_bit <= 1'b0;
        end else begin
            forced_stop_bit <= bus_wr && reg_idx == `IDX_CTRL && fetch_from_ram && pwdata[`STOP_BIT];
        end
    end
    assign stop_req = forced_stop_bit;

    // Stored on both parts; only the emulation part uses it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_duration_code <= `WT_RESET;
        end else if (bus_wr && reg_idx == `IDX_WTIME) begin
            write_duration_code <= pwdata[`WT_HI:0];
        end
    end

    // Reserved codes fall back to the shortest legal time
    assign eff_code = (write_duration_code > `WT_CODE_MAX) ? `WT_CODE_MAX : write_duration_code;

    // Bytes are refused while locked, warming up or programming
    assign wr_accept = flash_wr_strobe && (write_protect_key == `KEY_ENABLE) &&
                       (state == ST_IDLE || state == ST_LOAD) && !stop_req;

    assign warm_done = (state == ST_WARM) &&
                       (warm_slow ? (slow_tick && tcount[10:0] == `WARM_SLOW - 11'h1)
                                  : (tcount[10:0] == `WARM_FAST - 11'h1));
    assign prog_end  = (state == ST_PROG) && (!prog_slow || slow_tick) &&
                       (tcount == prog_len - 17'h1);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (power_restore) begin
                    next_state = ST_WARM;
                end else if (wr_accept) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (stop_req || power_restore) begin
                    next_state = ST_WARM;
                end else if (wr_accept && byte_count == `BUF_BYTES - 7'h1) begin
                    next_state = ST_PROG;
                end
            end
            ST_PROG: begin
                if (stop_req) begin
                    next_state = ST_WARM;
                end else if (prog_end) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WARM: begin
                if (warm_done) begin
                    next_state = warm_from_stop ? ST_IDLE : ret_state;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // CPU is held for exactly the warm-up; interrupts stay latched outside
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= ST_IDLE;
            cpu_wait <= 1'b0;
        end else begin
            state    <= next_state;
            cpu_wait <= (next_state == ST_WARM);
        end
    end

    // Warm-up context captured on entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_slow      <= 1'b0;
            warm_from_stop <= 1'b0;
            ret_state      <= ST_IDLE;
        end else if (state != ST_WARM && next_state == ST_WARM) begin
            warm_slow      <= clock_source_select;
            warm_from_stop <= stop_req;
            ret_state      <= state;
        end
    end

    // Shared counter for warm-up and write time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tcount <= 17'h0;
        end else if (state != next_state) begin
            tcount <= 17'h0;
        end else if (state == ST_WARM && (!warm_slow || slow_tick)) begin
            tcount <= tcount + 17'h1;
        end else if (state == ST_PROG && (!prog_slow || slow_tick)) begin
            tcount <= tcount + 17'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_len  <= 17'h1;
            prog_slow <= 1'b0;
        end else if (state == ST_LOAD && next_state == ST_PROG) begin
            if (!EMULATION) begin
                prog_len  <= WRITE_LEN;
                prog_slow <= 1'b0;
            end else if (clock_source_select) begin
                prog_len  <= 17'h1 << (`WT_SLOW_EXP - {2'h0, eff_code});
                prog_slow <= 1'b1;
            end else begin
                prog_len  <= 17'h1 << (`WT_FAST_EXP - {2'h0, eff_code});
                prog_slow <= 1'b0;
            end
        end
    end

    // Byte counter: cleared by a stop, so the next byte lands at index zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byte_count <= 7'h0;
        end else if (stop_req || next_state == ST_IDLE) begin
            byte_count <= 7'h0;
        end else if (wr_accept) begin
            byte_count <= byte_count + 7'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_we    <= 1'b0;
            buf_index <= 6'h0;
            buf_data  <= 8'h0;
        end else begin
            buf_we <= wr_accept;
            if (wr_accept) begin
                buf_index <= byte_count[5:0];
                buf_data  <= flash_wr_data;
            end
        end
    end

    // Busy from the first byte until the write ends or a stop warm-up ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_busy_flag <= 1'b0;
        end else if (wr_accept) begin
            write_busy_flag <= 1'b1;
        end else if (prog_end || (warm_done && warm_from_stop)) begin
            write_busy_flag <= 1'b0;
        end
    end

    // Array strobes; a partial page never reaches the array
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_start <= 1'b0;
            prog_done  <= 1'b0;
            prog_abort <= 1'b0;
        end else begin
            prog_start <= (state == ST_LOAD) && (next_state == ST_PROG);
            prog_done  <= prog_end && !stop_req;
            prog_abort <= (state == ST_PROG) && stop_req;
        end
    end

    // Helper: length of the last wait
    logic [10:0] warm_len;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_len <= 11'h0;
        end else if ($rose(cpu_wait)) begin
            warm_len <= 11'h1;
        end else if (cpu_wait) begin
            warm_len <= warm_len + 11'h1;
        end
    end

    sequence s_stop_busy;
        stop_req && (state == ST_LOAD || state == ST_PROG);
    endsequence

    sequence s_wait_starts;
        ##1 cpu_wait;
    endsequence

    a_key_reset_lock: assert property (@(posedge clk) $rose(rst_n) |-> write_protect_key == `KEY_LOCK)
        else $error("key not locked after reset");
    a_key_flash_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && !fetch_from_ram) |=> $stable(write_protect_key))
        else $error("key changed by flash-fetched write");
    a_locked_no_byte: assert property (@(posedge clk) disable iff (!rst_n)
        (flash_wr_strobe && write_protect_key != `KEY_ENABLE) |=> !buf_we)
        else $error("byte accepted while locked");
    a_stop_warm_start: assert property (@(posedge clk) disable iff (!rst_n)
        s_stop_busy |-> s_wait_starts ##0 (byte_count == 7'h0))
        else $error("stop did not start warm-up");
    a_stop_idle_nowait: assert property (@(posedge clk) disable iff (!rst_n)
        (stop_req && state == ST_IDLE && !power_restore) |=> !cpu_wait)
        else $error("warm-up without busy write");
    a_warm_fast_len: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(cpu_wait) && !warm_slow) |-> warm_len == `WARM_FAST)
        else $error("fast warm-up length wrong");
    a_busy_clear_end: assert property (@(posedge clk) disable iff (!rst_n)
        (warm_done && warm_from_stop) |=> !write_busy_flag && !cpu_wait)
        else $error("busy not cleared after stop warm-up");
    a_partial_no_prog: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_LOAD && stop_req) |=> !prog_start [*2])
        else $error("partial page programmed");
    a_stop_self_clear: assert property (@(posedge clk) disable iff (!rst_n)
        forced_stop_bit |=> !forced_stop_bit)
        else $error("stop bit did not clear");
    a_restore_warm: assert property (@(posedge clk) disable iff (!rst_n)
        (power_restore && state == ST_IDLE) |=> cpu_wait)
        else $error("power restore without warm-up");
    a_wtime_readback: assert property (@(posedge clk) disable iff (!rst_n)
        (bus_rd && reg_idx == `IDX_WTIME && mapped) |=> prdata[31:3] == 29'h0 && prdata[2:0] == write_duration_code)
        else $error("write-time readback wrong");

    // Helper: slow ticks seen while the CPU is held; the final tick ends the wait
    logic [10:0] warm_ticks;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            warm_ticks <= 11'h0;
        end else if (!cpu_wait) begin
            warm_ticks <= 11'h0;
        end else if (slow_tick) begin
            warm_ticks <= warm_ticks + 11'h1;
        end
    end

    a_warm_slow_len: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(cpu_wait) && warm_slow) |-> warm_ticks == `WARM_SLOW)
        else $error("slow warm-up length wrong");
    a_byte_sets_busy: assert property (@(posedge clk) disable iff (!rst_n)
        wr_accept |=> write_busy_flag && buf_we)
        else $error("accepted byte did not set busy");
    a_abort_on_stop: assert property (@(posedge clk) disable iff (!rst_n)
        (state == ST_PROG && stop_req) |=> prog_abort && cpu_wait && !prog_done)
        else $error("page write not aborted by stop");
    a_stop_flash_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && !fetch_from_ram) |=> !forced_stop_bit)
        else $error("stop taken from flash-fetched write");

endmodule : flash_write_protect_abort_warmup

// ===== verification/flash_cpu_model.sv
`timescale 1ns/100ps

module flash_cpu_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Bench control
    input  wire logic       go,
    input  wire logic [6:0] nbytes,
    // Buffer writes seen from the block
    input  wire logic       buf_we,
    input  wire logic [5:0] buf_index,
    // Byte writes into the flash area
    output logic            flash_wr_strobe,
    output logic [7:0]      flash_wr_data,
    // Observation
    output logic [6:0]      seen,
    output logic [5:0]      first_index
);
    logic [6:0] left;

    // One byte a cycle, in order, as a tight store loop issues them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left            <= 7'h0;
            flash_wr_strobe <= 1'b0;
            flash_wr_data   <= 8'h00;
        end else if (go) begin
            left            <= nbytes;
            flash_wr_strobe <= 1'b0;
        end else if (left != 7'h0) begin
            flash_wr_strobe <= 1'b1;
            flash_wr_data   <= 8'ha0 + {1'b0, left};
            left            <= left - 7'h1;
        end else begin
            flash_wr_strobe <= 1'b0;
            // Idle data must not look like a held byte
            flash_wr_data   <= ~flash_wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen        <= 7'h0;
            first_index <= 6'h3f;
        end else if (go) begin
            seen        <= 7'h0;
            first_index <= 6'h3f;
        end else if (buf_we) begin
            if (seen == 7'h0) begin
                first_index <= buf_index;
            end
            seen <= seen + 7'h1;
        end
    end
endmodule : flash_cpu_model

// ===== verification/tb_flash_write_protect_abort_warmup.sv
`timescale 1ns/100ps

module tb_flash_write_protect_abort_warmup;
    localparam logic [15:0] A_CTRL = 16'h3f80;
    localparam logic [15:0] A_STAT = 16'h3f84;
    localparam logic [15:0] A_WT   = 16'h3f88;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic        fetch_from_ram = 1'b0, css = 1'b0, slow_tick = 1'b0, power_restore = 1'b0;
    logic        go = 1'b0;
    logic [6:0]  nbytes = 7'h0;
    wire logic   pready, pslverr, flash_wr_strobe, buf_we, prog_start, prog_done, prog_abort;
    wire logic   write_busy_flag, cpu_wait;
    wire logic [31:0] prdata;
    wire logic [7:0]  flash_wr_data, buf_data;
    wire logic [5:0]  buf_index, first_index;
    wire logic [6:0]  seen;
    int          err_count = 0, compares = 0, cycles = 0;
    int          n_start = 0, n_done = 0, n_abort = 0, n;
    logic [31:0] rd;
    logic        perr;

    always #25 clk = ~clk;

    // Slow clock modelled as one tick every fourth cycle
    always @(posedge clk) begin
        cycles    <= cycles + 1;
        slow_tick <= (cycles % 4 == 3);
        if (cycles == 30000) begin
            err_count++;
            final_report();
        end
    end

    // Pulses are counted mid-cycle where they are settled
    always @(negedge clk) begin
        if (prog_start === 1'b1) n_start++;
        if (prog_done === 1'b1) n_done++;
        if (prog_abort === 1'b1) n_abort++;
    end

    flash_write_protect_abort_warmup #(.EMULATION(1'b1), .WRITE_CYCLES(64)) dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .fetch_from_ram(fetch_from_ram), .clock_source_select(css), .slow_tick(slow_tick),
        .power_restore(power_restore), .flash_wr_strobe(flash_wr_strobe),
        .flash_wr_data(flash_wr_data), .buf_we(buf_we), .buf_index(buf_index),
        .buf_data(buf_data), .prog_start(prog_start), .prog_done(prog_done),
        .prog_abort(prog_abort), .write_busy_flag(write_busy_flag), .cpu_wait(cpu_wait));

    flash_cpu_model cpu (
        .clk(clk), .rst_n(rst_n), .go(go), .nbytes(nbytes), .buf_we(buf_we),
        .buf_index(buf_index), .flash_wr_strobe(flash_wr_strobe),
        .flash_wr_data(flash_wr_data), .seen(seen), .first_index(first_index));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic ram);
        int k;
        @(posedge clk);
        psel           <= 1'b1;
        penable        <= 1'b0;
        pwrite         <= wr;
        paddr          <= a;
        pwdata         <= d;
        fetch_from_ram <= ram;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        // Values read right after the edge are those the edge sampled
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) chk(1'b0, 1'b1, "apb answer");
        rd   = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic send(input int cnt);
        go     <= 1'b1;
        nbytes <= cnt[6:0];
        @(posedge clk);
        go <= 1'b0;
        repeat (cnt + 4) @(posedge clk);
    endtask : send

    task automatic warm_len(output int len);
        int k;
        k   = 0;
        len = 0;
        do begin
            @(negedge clk);
            k++;
        end while (cpu_wait !== 1'b1 && k < 8);
        while (cpu_wait === 1'b1 && len < 3000) begin
            @(negedge clk);
            len++;
        end
    endtask : warm_len

    task automatic t_regs;
        apb(1'b0, A_CTRL, 32'h0, 1'b1);
        chk(rd[7:4], 4'hc, "key after reset");
        apb(1'b0, A_WT, 32'h0, 1'b1);
        chk(rd[2:0], 3'h0, "time code after reset");
        apb(1'b1, A_CTRL, 32'h30, 1'b0);
        apb(1'b0, A_CTRL, 32'h0, 1'b1);
        chk(rd[7:4], 4'hc, "key write from flash");
        send(3);
        chk(seen, 7'h0, "bytes while locked");
        apb(1'b1, A_CTRL, 32'h30, 1'b1);
        apb(1'b0, A_CTRL, 32'h0, 1'b1);
        chk(rd[7:4], 4'h3, "key write from ram");
        apb(1'b1, A_WT, 32'hff, 1'b1);
        apb(1'b0, A_WT, 32'h0, 1'b1);
        chk(rd[2:0], 3'h7, "time code readback");
        apb(1'b1, A_WT, 32'h4, 1'b1);
        apb(1'b1, 16'h3f90, 32'h0, 1'b1);
        chk(perr, 1'b1, "unmapped address");
    endtask : t_regs

    task automatic t_partial;
        send(10);
        chk(seen, 7'd10, "partial bytes taken");
        chk(first_index, 6'h00, "first byte slot");
        chk(buf_index, 6'h09, "last byte slot");
        chk(buf_data, 8'ha1, "last byte data");
        chk(write_busy_flag, 1'b1, "busy after load");
        apb(1'b1, A_CTRL, 32'h34, 1'b0);
        apb(1'b0, A_STAT, 32'h0, 1'b1);
        chk(rd[0], 1'b1, "stop from flash");
        apb(1'b1, A_CTRL, 32'h34, 1'b1);
        warm_len(n);
        chk(n, 1024, "fast warm-up length");
        chk(write_busy_flag, 1'b0, "busy after warm-up");
        chk(n_start, 0, "partial page kept");
        apb(1'b0, A_CTRL, 32'h0, 1'b1);
        chk(rd[2], 1'b0, "stop bit reads back");
        apb(1'b1, A_CTRL, 32'h34, 1'b1);
        warm_len(n);
        chk(n, 0, "stop while idle");
    endtask : t_partial

    task automatic t_full;
        int k;
        send(64);
        chk(n_start, 1, "page write start");
        k = 0;
        while (n_done == 0 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        chk((k > 4080) && (k <= 4096), 1'b1, "write time code four");
        chk(write_busy_flag, 1'b0, "busy after write");
        send(64);
        apb(1'b1, A_CTRL, 32'h34, 1'b1);
        warm_len(n);
        chk(n_abort, 1, "abort of page write");
        chk(n, 1024, "warm-up after abort");
    endtask : t_full

    task automatic t_slow_power;
        css <= 1'b1;
        // Gap after each stop keeps flash accesses a cycle away
        send(5);
        apb(1'b1, A_CTRL, 32'h34, 1'b1);
        warm_len(n);
        chk((n >= 28) && (n <= 33), 1'b1, "slow warm-up length");
        css <= 1'b0;
        @(posedge clk);
        power_restore <= 1'b1;
        @(posedge clk);
        power_restore <= 1'b0;
        warm_len(n);
        chk(n, 1024, "power-up wait");
    endtask : t_slow_power

    task automatic final_report;
        $display("Checks: %0d compares, %0d errors", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_partial();
        t_full();
        t_slow_power();
        final_report();
    end
endmodule : tb_flash_write_protect_abort_warmup
